// ==== bench/neighbour_feed.sv ====
// neighbour node model feeding one receive access point of the relay
`timescale 1ns/1ps
`default_nettype none
module neighbour_feed (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// request from the bench
	input wire logic req,
	input wire logic [1:0] kind,
	input wire logic [7:0] octet,
	output logic busy,
	// receive side of the relay
	output logic [7:0] rxOctet,
	output logic [1:0] rxKind,
	output logic rxStrobe
);
	logic [3:0] step_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			step_ff <= 4'h0;
			busy <= 1'b0;
			rxStrobe <= 1'b0;
			rxOctet <= 8'h00;
			rxKind <= 2'h0;
		end else if (step_ff == 4'h0) begin
			if (req) begin
				rxOctet <= octet; // whole octet, subfields as given
				rxKind <= kind;
				step_ff <= 4'h1;
				busy <= 1'b1;
			end else begin
				// released lines toggle so no stale value looks valid
				rxOctet <= ~rxOctet;
				rxKind <= ~rxKind;
			end
		end else begin
			// data held three cycles before and four cycles after the strobe for the synchroniser
			rxStrobe <= (step_ff == 4'h3);
			step_ff <= (step_ff == 4'h7) ? 4'h0 : step_ff + 4'h1;
			busy <= (step_ff != 4'h7);
		end
	end
endmodule : neighbour_feed
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the dual-bus field relay
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import field_relay_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] rxOctetA, rxOctetB, txOctetA, txOctetB;
	logic [1:0] rxKindA, rxKindB, txKindA, txKindB;
	logic rxStrobeA, rxStrobeB, txStrobeA, txStrobeB;
	logic retainStrobe, acquireStrobe;
	logic [PAGE_W-1:0] retainPage, acquirePage;
	logic reqA = 1'b0;
	logic reqB = 1'b0;
	logic [1:0] kindReq = 2'h0;
	logic [7:0] octReq = 8'h00;
	logic busyA, busyB;
	logic [9:0] lastA = '0;
	logic [9:0] lastB = '0;
	logic [9:0] lastRetain = '0;
	logic [9:0] lastAcq = '0;
	logic [7:0] genExp [5] = '{8'h08, 8'h03, 8'h05, 8'h06, 8'h00};
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;
	dual_bus_field_relay dual_bus_field_relay_inst (.clk(clk), .reset_n(reset_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready),
		.rxOctetA(rxOctetA), .rxKindA(rxKindA), .rxStrobeA(rxStrobeA),
		.rxOctetB(rxOctetB), .rxKindB(rxKindB), .rxStrobeB(rxStrobeB),
		.txOctetA(txOctetA), .txKindA(txKindA), .txStrobeA(txStrobeA),
		.txOctetB(txOctetB), .txKindB(txKindB), .txStrobeB(txStrobeB),
		.retainStrobe(retainStrobe), .retainPage(retainPage),
		.acquireStrobe(acquireStrobe), .acquirePage(acquirePage));
	neighbour_feed feedA (.clk(clk), .reset_n(reset_n), .req(reqA), .kind(kindReq),
		.octet(octReq), .busy(busyA), .rxOctet(rxOctetA), .rxKind(rxKindA), .rxStrobe(rxStrobeA));
	neighbour_feed feedB (.clk(clk), .reset_n(reset_n), .req(reqB), .kind(kindReq),
		.octet(octReq), .busy(busyB), .rxOctet(rxOctetB), .rxKind(rxKindB), .rxStrobe(rxStrobeB));
	// capture what leaves each access point
	always @(posedge clk) begin
		if (txStrobeA === 1'b1) begin
			lastA <= {txKindA, txOctetA};
		end
		if (txStrobeB === 1'b1) begin
			lastB <= {txKindB, txOctetB};
		end
		if (retainStrobe === 1'b1) begin
			lastRetain <= retainPage;
		end
		if (acquireStrobe === 1'b1) begin
			lastAcq <= acquirePage;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic reg_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (aw && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (w && wready === 1'b1) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
		end while (aw || w);
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : reg_write
	task automatic reg_read(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		check("rdata", e, rdata);
		check("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : reg_read
	task automatic cfg(input logic [31:0] v);
		reg_write({REG_CTRL, 2'b00}, v, 4'hf, RESP_OKAY);
	endtask : cfg
	// one octet in on bus b (0 = A), compare what leaves the same bus
	task automatic step(input logic b, input logic [1:0] k, input logic [7:0] o,
		input logic [7:0] e);
		@(posedge clk);
		kindReq <= k;
		octReq <= o;
		reqA <= !b;
		reqB <= b;
		@(posedge clk);
		reqA <= 1'b0;
		reqB <= 1'b0;
		do @(posedge clk); while (busyA === 1'b1 || busyB === 1'b1);
		repeat (3) @(posedge clk);
		check(b ? "txB" : "txA", {22'h0, k, e}, {22'h0, b ? lastB : lastA});
	endtask : step
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 5; i++) begin
			reg_read(5'(i * 4), 32'h0000_0000, RESP_OKAY);
		end
		reg_read(5'h14, 32'h0000_0000, RESP_SLVERR);
		reg_write(5'h14, 32'hffff_ffff, 4'hf, RESP_SLVERR);
		reg_write({REG_RSV, 2'b00}, 32'hffff_ffff, 4'hf, RESP_OKAY);
		reg_read({REG_RSV, 2'b00}, 32'h0000_03ff, RESP_OKAY);
		reg_write({REG_PAGES, 2'b00}, 32'hffff_ffff, 4'hf, RESP_OKAY);
		reg_read({REG_PAGES, 2'b00}, 32'h0000_0000, RESP_OKAY);
		cfg(32'h0000_0000);
		step(0, KIND_SLOT, 8'h5a, 8'h5a);
		step(1, KIND_SLOT, 8'ha5, 8'ha5);
		step(0, KIND_OTHER, 8'h33, 8'h33);
		step(1, KIND_IDENT, 8'h77, 8'h77);
		step(0, KIND_IDENT, 8'h66, 8'h66);
		step(0, KIND_PAGE, 8'h09, 8'h09);
		cfg(32'h0000_0001);
		step(0, KIND_SLOT, 8'h5a, 8'h00);
		step(1, KIND_SLOT, 8'h5a, 8'h5a);
		step(0, KIND_IDENT, 8'h77, IDENT_A_DEF);
		step(1, KIND_IDENT, 8'h01, 8'h01);
		step(0, KIND_IDENT, 8'h77, 8'h02);
		step(1, KIND_IDENT, 8'h66, 8'h66);
		step(0, KIND_IDENT, 8'h77, 8'h02);
		step(0, KIND_PAGE, 8'h5f, 8'h00);
		step(1, KIND_PAGE, 8'h0b, 8'h00);
		cfg(32'h0000_0009);
		step(0, KIND_IDENT, 8'h77, 8'h01);
		cfg(32'h0000_0002);
		step(0, KIND_IDENT, 8'h02, 8'h02);
		step(1, KIND_IDENT, 8'h77, 8'h01);
		step(0, KIND_IDENT, 8'h55, 8'h55);
		step(1, KIND_IDENT, 8'h77, 8'h01);
		step(0, KIND_PAGE, 8'h05, 8'h05);
		step(1, KIND_PAGE, 8'h77, 8'h05);
		cfg(32'h0000_000a);
		step(1, KIND_IDENT, 8'h77, 8'h02);
		cfg(32'h0000_0004);
		step(0, KIND_IDENT, 8'h77, 8'h01);
		step(1, KIND_IDENT, 8'h77, 8'h02);
		// generator: page 0 with reset first, then pages 1..4, pages up to 2 reserved
		reg_write({REG_RSV, 2'b00}, 32'h0000_0002, 4'hf, RESP_OKAY);
		cfg(32'h0000_0011);
		for (int i = 0; i < 5; i++) begin
			step(0, KIND_PAGE, 8'ha0, genExp[i]);
			if (i > 0) begin
				check("retainPage", 32'(i), {22'h0, lastRetain});
			end
		end
		reg_read({REG_PAGES, 2'b00}, 32'h0000_0005, RESP_OKAY);
		// plain node acquiring on bus B
		cfg(32'h0000_0020);
		reg_write({REG_STATUS, 2'b00}, 32'h0000_0007, 4'h1, RESP_OKAY);
		reg_read({REG_STATUS, 2'b00}, 32'h0000_0000, RESP_OKAY);
		step(1, KIND_PAGE, 8'h08, 8'h08);
		step(1, KIND_PAGE, 8'h02, 8'h02);
		check("acquirePage", 32'h0000_0001, {22'h0, lastAcq});
		// reserved field with a wrong modulus: flagged, never acquired
		step(1, KIND_PAGE, 8'h01, 8'h01);
		check("acquirePage", 32'h0000_0001, {22'h0, lastAcq});
		reg_read({REG_STATUS, 2'b00}, 32'h0000_0006, RESP_OKAY);
		reg_read({REG_ACQ, 2'b00}, 32'h0000_0001, RESP_OKAY);
		reg_read({REG_PAGES, 2'b00}, 32'h0003_0005, RESP_OKAY);
		// clear only takes effect with the low byte strobed
		reg_write({REG_STATUS, 2'b00}, 32'h0000_0007, 4'h2, RESP_OKAY);
		reg_read({REG_STATUS, 2'b00}, 32'h0000_0006, RESP_OKAY);
		reg_write({REG_STATUS, 2'b00}, 32'h0000_0007, 4'h1, RESP_OKAY);
		reg_read({REG_STATUS, 2'b00}, 32'h0000_0000, RESP_OKAY);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire

// ==== hw/dual_bus_field_relay.sv ====
// relay of slot and management octets between the two bus access points
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dual_bus_field_relay #(
	parameter logic [7:0] ID_CODE_A = field_relay_pkg::IDENT_A_DEF,
	parameter logic [7:0] ID_CODE_B = field_relay_pkg::IDENT_B_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// axi4-lite register slave
	input wire logic [field_relay_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [field_relay_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// bus A receive side
	input wire logic [7:0] rxOctetA,
	input wire logic [1:0] rxKindA,
	input wire logic rxStrobeA,
	// bus B receive side
	input wire logic [7:0] rxOctetB,
	input wire logic [1:0] rxKindB,
	input wire logic rxStrobeB,
	// bus A transmit side
	output logic [7:0] txOctetA,
	output logic [1:0] txKindA,
	output logic txStrobeA,
	// bus B transmit side
	output logic [7:0] txOctetB,
	output logic [1:0] txKindB,
	output logic txStrobeB,
	// page events for the node page list
	output logic retainStrobe,
	output logic [field_relay_pkg::PAGE_W-1:0] retainPage,
	output logic acquireStrobe,
	output logic [field_relay_pkg::PAGE_W-1:0] acquirePage
);
	import field_relay_pkg::*;

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [RX_W-1:0] r1A;
		logic [RX_W-1:0] r2A;
		logic [RX_W-1:0] r1B;
		logic [RX_W-1:0] r2B;
		logic [7:0] txOctA;
		logic [7:0] txOctB;
		logic [1:0] txKindA;
		logic [1:0] txKindB;
		logic txStbA;
		logic txStbB;
		logic [7:0] lastRawA;
		logic [7:0] lastValA;
		logic [7:0] lastRawB;
		logic [7:0] lastValB;
		logic [7:0] pageHold;
		logic [PAGE_W-1:0] genPage;
		logic [PAGE_W-1:0] pageA;
		logic [PAGE_W-1:0] pageB;
		logic errA;
		logic errB;
		logic acqFlag;
		logic [PAGE_W-1:0] acqPage;
		logic retStb;
		logic [PAGE_W-1:0] retPage;
		logic acqStb;
		logic [PAGE_W-1:0] acqOutPage;
		logic [5:0] ctrl;
		logic [PAGE_W-1:0] rsvPages;
		logic awHeld;
		logic wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} state_t;

	state_t st;
	state_t nxt;

	////////////////////////////////////////////////////////////////////////////

	function automatic logic isIdent(input logic [7:0] v);
		return (v == ID_CODE_A) || (v == ID_CODE_B);
	endfunction : isIdent

	function automatic logic [7:0] oppose(input logic [7:0] v);
		return (v == ID_CODE_A) ? ID_CODE_B : ID_CODE_A;
	endfunction : oppose

	// identity value for one outgoing bus
	function automatic logic [7:0] identFor(
		input logic forA,
		input logic head,
		input logic dfltGen,
		input logic isle,
		input logic [7:0] thru,
		input logic [7:0] endRaw,
		input logic [7:0] endVal
	);
		logic [7:0] own;
		own = forA ? ID_CODE_A : ID_CODE_B;
		if (dfltGen) begin
			return own;
		end
		if (!head) begin
			return thru;
		end
		if (isle && forA) begin
			return ID_CODE_A;
		end
		if (isIdent(endRaw)) begin
			return oppose(endRaw);
		end
		// isolated head B keeps its own code on garbage
		if (isle || !isIdent(endVal)) begin
			return own;
		end
		return oppose(endVal);
	endfunction : identFor

	// counter control decides the page of the next field
	function automatic logic [PAGE_W-1:0] nextPage(
		input logic [PAGE_W-1:0] p,
		input logic rst
	);
		if (rst) begin
			return MIN_PAGE;
		end
		if ((p == '0) || (p == MAX_PAGE)) begin
			return '0;
		end
		return p + 1'b1;
	endfunction : nextPage

	function automatic logic [1:0] pcmOf(input logic [7:0] v);
		return v[PGF_MOD_LSB +: 2];
	endfunction : pcmOf

	// byte-lane merge of a register write
	function automatic logic [31:0] wmerge(
		input logic [31:0] old,
		input logic [31:0] d,
		input logic [3:0] s
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	////////////////////////////////////////////////////////////////////////////

	logic stbA;
	logic stbB;
	logic [1:0] kindA;
	logic [1:0] kindB;
	logic [7:0] octA;
	logic [7:0] octB;
	logic headA;
	logic headB;
	logic dflt;
	logic island;
	logic alloc;
	logic acqReq;
	logic genCtlRst;
	logic genRsv;
	logic [7:0] genField;

	// only the second synchroniser stage feeds logic
	assign stbA = st.r2A[10];
	assign kindA = st.r2A[9:8];
	assign octA = st.r2A[7:0];
	assign stbB = st.r2B[10];
	assign kindB = st.r2B[9:8];
	assign octB = st.r2B[7:0];
	assign headA = st.ctrl[CTRL_HEAD_A];
	assign headB = st.ctrl[CTRL_HEAD_B];
	assign dflt = st.ctrl[CTRL_DFLT];
	assign island = st.ctrl[CTRL_ISLAND];
	assign alloc = st.ctrl[CTRL_ALLOC];
	assign acqReq = st.ctrl[CTRL_ACQ_REQ];

	// head of A field generator
	assign genCtlRst = alloc && ((st.genPage == '0) || (st.genPage == MAX_PAGE));
	assign genRsv = alloc && (st.genPage != '0) && (st.genPage <= st.rsvPages);
	assign genField = {4'h0, genCtlRst, st.genPage[1:0], genRsv};

	////////////////////////////////////////////////////////////////////////////

	always_comb begin : next_state
		logic [31:0] wv;
		logic errSetA;
		logic errSetB;
		logic acqSet;
		wv = '0;
		errSetA = 1'b0;
		errSetB = 1'b0;
		acqSet = 1'b0;
		nxt = st;
		// two flops per pin; octet data rides with its strobe
		nxt.r1A = {rxStrobeA, rxKindA, rxOctetA};
		nxt.r2A = st.r1A;
		nxt.r1B = {rxStrobeB, rxKindB, rxOctetB};
		nxt.r2B = st.r1B;

		// bus A outgoing octet
		nxt.txStbA = stbA;
		nxt.txKindA = kindA;
		nxt.txOctA = octA;
		if (stbA) begin
			unique case (kindA)
				KIND_SLOT: begin
					if (headA) begin
						nxt.txOctA = 8'h00;
					end
				end
				KIND_IDENT: begin
					nxt.txOctA = identFor(1'b1, headA, dflt, island, octA, st.lastRawB,
						st.lastValB);
				end
				KIND_PAGE: begin
					if (headA) begin
						nxt.txOctA = genField;
						nxt.genPage = nextPage(st.genPage, genCtlRst);
					end
				end
				KIND_OTHER: begin
				end
			endcase
		end
		if (!alloc) begin
			nxt.genPage = '0;
		end

		// bus B outgoing octet
		nxt.txStbB = stbB;
		nxt.txKindB = kindB;
		nxt.txOctB = octB;
		if (stbB) begin
			unique case (kindB)
				KIND_SLOT: begin
					if (headB) begin
						nxt.txOctB = 8'h00;
					end
				end
				KIND_IDENT: begin
					nxt.txOctB = identFor(1'b0, headB, dflt, island, octB, st.lastRawA,
						st.lastValA);
				end
				KIND_PAGE: begin
					if (headB) begin
						nxt.txOctB = st.pageHold;
					end else if (headA) begin
						nxt.txOctB = 8'h00;
					end
				end
				KIND_OTHER: begin
				end
			endcase
		end

		// what the far ends of the buses last delivered
		if (stbA && (kindA == KIND_IDENT)) begin
			nxt.lastRawA = octA;
			if (isIdent(octA)) begin
				nxt.lastValA = octA;
			end
		end
		if (stbB && (kindB == KIND_IDENT)) begin
			nxt.lastRawB = octB;
			if (isIdent(octB)) begin
				nxt.lastValB = octB;
			end
		end
		if (stbA && (kindA == KIND_PAGE)) begin
			nxt.pageHold = octA;
		end

		// node page tracking on what passes this node
		nxt.retStb = 1'b0;
		nxt.acqStb = 1'b0;
		if (st.txStbA && (st.txKindA == KIND_PAGE)) begin
			if ((st.pageA != '0) && (pcmOf(st.txOctA) != st.pageA[1:0])) begin
				errSetA = 1'b1;
			end
			if (st.pageA != '0) begin
				nxt.retStb = 1'b1;
				nxt.retPage = st.pageA;
			end
			nxt.pageA = nextPage(st.pageA, st.txOctA[PGF_CTL_BIT]);
		end
		if (st.txStbB && (st.txKindB == KIND_PAGE)) begin
			if ((st.pageB != '0) && (pcmOf(st.txOctB) != st.pageB[1:0])) begin
				errSetB = 1'b1;
			end
			if (acqReq && (st.pageB != '0) && !st.txOctB[PGF_RSV_BIT]) begin
				nxt.acqStb = 1'b1;
				nxt.acqOutPage = st.pageB;
				acqSet = 1'b1;
			end
			nxt.pageB = nextPage(st.pageB, st.txOctB[PGF_CTL_BIT]);
		end

		// register write, both halves taken in either order
		if (awvalid && st.awReady) begin
			nxt.awHeld = 1'b1;
			nxt.awAddr = awaddr;
		end
		if (wvalid && st.wReady) begin
			nxt.wHeld = 1'b1;
			nxt.wData = wdata;
			nxt.wStrb = wstrb;
		end
		if (bready && st.bValid) begin
			nxt.bValid = 1'b0;
		end
		if (st.awHeld && st.wHeld) begin
			nxt.awHeld = 1'b0;
			nxt.wHeld = 1'b0;
			nxt.bValid = 1'b1;
			nxt.bResp = RESP_OKAY;
			unique case (st.awAddr[ADDR_W-1:2])
				REG_CTRL: begin
					wv = wmerge({26'h0, st.ctrl}, st.wData, st.wStrb);
					nxt.ctrl = wv[5:0];
				end
				REG_RSV: begin
					wv = wmerge({22'h0, st.rsvPages}, st.wData, st.wStrb);
					nxt.rsvPages = wv[PAGE_W-1:0];
				end
				REG_STATUS: begin
					// write one to clear
					wv = st.wStrb[0] ? st.wData : 32'h0000_0000;
					nxt.errA = st.errA && !wv[ST_ERR_A];
					nxt.errB = st.errB && !wv[ST_ERR_B];
					nxt.acqFlag = st.acqFlag && !wv[ST_ACQ];
				end
				REG_PAGES, REG_ACQ: begin
				end
				default: begin
					nxt.bResp = RESP_SLVERR;
				end
			endcase
		end
		// a new event beats a clear in the same cycle
		if (errSetA) begin
			nxt.errA = 1'b1;
		end
		if (errSetB) begin
			nxt.errB = 1'b1;
		end
		if (acqSet) begin
			nxt.acqFlag = 1'b1;
			nxt.acqPage = st.pageB;
		end
		nxt.awReady = !nxt.awHeld && !nxt.bValid;
		nxt.wReady = !nxt.wHeld && !nxt.bValid;

		// register read
		if (rready && st.rValid) begin
			nxt.rValid = 1'b0;
		end
		if (arvalid && st.arReady) begin
			nxt.rValid = 1'b1;
			nxt.rResp = RESP_OKAY;
			unique case (araddr[ADDR_W-1:2])
				REG_CTRL: nxt.rData = {26'h0, st.ctrl};
				REG_RSV: nxt.rData = {22'h0, st.rsvPages};
				REG_STATUS: nxt.rData = {29'h0, st.acqFlag, st.errB, st.errA};
				REG_PAGES: nxt.rData = {6'h0, st.pageB, 6'h0, st.pageA};
				REG_ACQ: nxt.rData = {22'h0, st.acqPage};
				default: begin
					nxt.rData = 32'h0000_0000;
					nxt.rResp = RESP_SLVERR;
				end
			endcase
		end
		nxt.arReady = !nxt.rValid;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	assign awready = st.awReady;
	assign wready = st.wReady;
	assign bvalid = st.bValid;
	assign bresp = st.bResp;
	assign arready = st.arReady;
	assign rvalid = st.rValid;
	assign rdata = st.rData;
	assign rresp = st.rResp;
	assign txOctetA = st.txOctA;
	assign txKindA = st.txKindA;
	assign txStrobeA = st.txStbA;
	assign txOctetB = st.txOctB;
	assign txKindB = st.txKindB;
	assign txStrobeB = st.txStbB;
	assign retainStrobe = st.retStb;
	assign retainPage = st.retPage;
	assign acquireStrobe = st.acqStb;
	assign acquirePage = st.acqOutPage;

	////////////////////////////////////////////////////////////////////////////

	a_relay_other: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbA && (kindA == KIND_OTHER) |=> txStrobeA && (txOctetA == $past(octA)))
		else $error("management octet on bus A not relayed");

	a_slot_forward: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbB && (kindB == KIND_SLOT) && !headB |=> txOctetB == $past(octB))
		else $error("slot octet on bus B altered by non-head");

	a_ident_default: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbB && (kindB == KIND_IDENT) && dflt |=> txOctetB == ID_CODE_B)
		else $error("default generator did not send bus B identity");

	a_ident_island: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbA && (kindA == KIND_IDENT) && !dflt && island && headA
		|=> txOctetA == ID_CODE_A)
		else $error("isolated head A did not send bus A identity");

	a_ident_relay: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbA && (kindA == KIND_IDENT) && !dflt && !headA |=> txOctetA == $past(octA))
		else $error("plain node changed identity field");

	a_field_copy: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbB && (kindB == KIND_PAGE) && headB |=> txOctetB == $past(st.pageHold))
		else $error("head B did not copy page field from bus A");

	a_field_drop: assert property (
		@(posedge clk) disable iff (!reset_n)
		stbB && (kindB == KIND_PAGE) && headA && !headB |=> txOctetB == 8'h00)
		else $error("head A forwarded page field from end of bus B");

	a_page_reset: assert property (
		@(posedge clk) disable iff (!reset_n)
		txStrobeB && (txKindB == KIND_PAGE) && txOctetB[PGF_CTL_BIT]
		|=> st.pageB == MIN_PAGE)
		else $error("counter control reset did not restart bus B page");

	a_pcm_check: assert property (
		@(posedge clk) disable iff (!reset_n)
		txStrobeA && (txKindA == KIND_PAGE) && (st.pageA != '0)
		&& (pcmOf(txOctetA) != st.pageA[1:0]) |=> st.errA)
		else $error("modulus mismatch on bus A not flagged");

	a_page_zero: assert property (
		@(posedge clk) disable iff (!reset_n)
		!alloc |=> st.genPage == '0)
		else $error("page number not zero while allocation disabled");

	a_acquire_free: assert property (
		@(posedge clk) disable iff (!reset_n)
		acquireStrobe |-> $past(txStrobeB) && ($past(txKindB) == KIND_PAGE)
		&& !$past(txOctetB[PGF_RSV_BIT]))
		else $error("page acquired from a reserved field");

endmodule : dual_bus_field_relay
`default_nettype wire

// ==== hw/field_relay_pkg.sv ====
// constants for the dual-bus management field relay
// How it works
// - every received octet passes between access points
// - non-head bus: no slot generation, plain forwarding
// - every node processes page fields on both buses
// - head of a bus originates its identity field
// - default generator node sets identity on both
// - other head sends opposite of received code
// - invalid code: opposite of last valid one
// - isolated segment: head A sends bus A code
// - isolated head B: opposite, else bus B code
// - plain node relays identity field unchanged
// - only head of A originates page fields
// - head of B copies field from end of A
// - head of A drops fields from end of B
// - acquire pages on bus B, retain on A
// - page field: reservation, modulus, counter control
// - counter control steers next field's page number
// - reservation bit marks page reserved or free
// - modulus subfield checks local page counter
// - one page holds one identifier value
// - enabled pages 1..max, otherwise zero
`default_nettype none
package field_relay_pkg;
	// octet kinds as they arrive with each strobe
	localparam logic [1:0] KIND_SLOT = 2'h0;
	localparam logic [1:0] KIND_IDENT = 2'h1;
	localparam logic [1:0] KIND_PAGE = 2'h2;
	localparam logic [1:0] KIND_OTHER = 2'h3;
	localparam int OCT_W = 8;
	localparam int RX_W = 11;
	// identity codes, plain defaults
	localparam logic [7:0] IDENT_A_DEF = 8'h01;
	localparam logic [7:0] IDENT_B_DEF = 8'h02;
	// page numbering
	localparam int PAGE_W = 10;
	localparam logic [9:0] MIN_PAGE = 10'h001;
	localparam logic [9:0] MAX_PAGE = 10'h3ff;
	// page field layout
	localparam int PGF_RSV_BIT = 0;
	localparam int PGF_MOD_LSB = 1;
	localparam int PGF_CTL_BIT = 3;
	// register map
	localparam int ADDR_W = 5;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_RSV = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_PAGES = 3'h3;
	localparam logic [2:0] REG_ACQ = 3'h4;
	localparam int CTRL_HEAD_A = 0;
	localparam int CTRL_HEAD_B = 1;
	localparam int CTRL_DFLT = 2;
	localparam int CTRL_ISLAND = 3;
	localparam int CTRL_ALLOC = 4;
	localparam int CTRL_ACQ_REQ = 5;
	localparam int ST_ERR_A = 0;
	localparam int ST_ERR_B = 1;
	localparam int ST_ACQ = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : field_relay_pkg
`default_nettype wire
